/* verilog/tcd_defines.svh */
// named offsets, field positions, reset values and limits of the capture/demodulation timer
`ifndef TCD_DEFINES_SVH
`define TCD_DEFINES_SVH

// register indices (byte address is four times the index)
`define TCD_IDX_COMMON_CONTROL 6'h01
`define TCD_IDX_RELOAD_HIGH 6'h07
`define TCD_IDX_WIDE_CAP_LOW 6'h08
`define TCD_IDX_WIDE_CAP_HIGH 6'h09
`define TCD_IDX_NARROW_CAP_LOW 6'h0A
`define TCD_IDX_NARROW_CAP_HIGH 6'h0B
`define TCD_IDX_AUX_CONTROL 6'h10
`define TCD_IDX_INT_STATUS 6'h11
`define TCD_IDX_INT_ENABLE 6'h12
`define TCD_IDX_INT_CLEAR 6'h13

// word index field inside haddr
`define TCD_ADDR_HI 7
`define TCD_ADDR_LO 2

// common control fields
`define TCD_CC_MODE 7
`define TCD_CC_SELECT 6
`define TCD_CC_EDGE_HI 5
`define TCD_CC_EDGE_LO 4
`define TCD_CC_RISE 1
`define TCD_CC_FALL 0

// demodulation edge selection codes
`define TCD_EDGE_FALLING 2'h0
`define TCD_EDGE_RISING 2'h1
`define TCD_EDGE_BOTH 2'h2

// aux control fields
`define TCD_AUX_RUN 0
`define TCD_AUX_PIN4_SELECT 1

// interrupt bit positions (status, enable and clear share them)
`define TCD_INT_CAPTURE 0
`define TCD_INT_TIMEOUT 1

// reset values and limits
`define TCD_RST_BYTE 8'h00
`define TCD_RST_INT 2'h0
`define TCD_NARROW_TOP 8'hFF
`define TCD_NARROW_ONE 8'h01
`define TCD_WIDE_ONE 16'h0001
`define TCD_RD_ZERO 32'h00000000
`define TCD_PAD_24 24'h000000
`define TCD_PAD_30 30'h00000000

`endif

/* verilog/tcd_pkg.sv */
// types shared by the capture/demodulation timer files
package tcd_pkg;

	// common mode bit meaning
	typedef enum logic {
		TCD_MODE_TRANSMIT = 1'b0,
		TCD_MODE_DEMOD = 1'b1
	} tcd_mode_type;

	// latched ahb address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [5:0] index;
	} tcd_req_type;

	// driven port 3 output pins
	typedef struct packed {
		logic port3Bit4Pin;
		logic port3Bit6Pin;
	} tcd_pin_type;

endpackage : tcd_pkg

/* verilog/tcd_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module tcd_sync (
	input wire logic core_clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic clkEn, // freezes state while low
	input wire logic asyncIn, // raw pin level
	output logic levelOut // filtered synchronous level
);

	logic ff1Reg, ff2Reg, ff3Reg, levelReg;
	logic levelNext;

	// level follows only once the second and third stages agree
	always_comb begin
		levelNext = levelReg;
		if (ff2Reg == ff3Reg) begin
			levelNext = ff3Reg;
		end
	end

	// shift chain and filtered level
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ff1Reg <= 1'b0;
			ff2Reg <= 1'b0;
			ff3Reg <= 1'b0;
			levelReg <= 1'b0;
		end else if (clkEn) begin
			ff1Reg <= asyncIn;
			ff2Reg <= ff1Reg;
			ff3Reg <= ff2Reg;
			levelReg <= levelNext;
		end
	end

	assign levelOut = levelReg;

endmodule : tcd_sync

/* verilog/tcd_top.sv */
// capture/demodulation timer pair with its register file on ahb-lite
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tcd_defines.svh"

// What this block does
// R1: narrow high-capture holds narrow count gathered while the demod input was one.
// R2: narrow low-capture holds narrow count gathered while the demod input was zero.
// R3: wide capture high byte shows the upper byte of the captured wide count.
// R4: wide capture low byte shows the lower byte of the captured wide count.
// R5: capture registers read captured data; writes to them change nothing.
// R6: wide reload high byte is a read/write software register.
// R7: capture interrupt enable lets demod captures raise the interrupt.
// R8: counter interrupt enable lets narrow counter timeout raise the interrupt.
// R9: a select bit drives port 3 bit 4 from port data or timer output.
// R10: common control bit 7 picks mode for both timers; reset gives transmit.
// R11: mode bit one selects demodulation meanings for the common control bits.
// R12: in demod, bit 6 picks input: zero port 3 bit 1, one port 2 bit 0.
// R13: in transmit, bit 6 zero keeps port 3 bit 6 as port output, reset default.
// R14: each selected demod edge moves running counts into captures by ended level, then restarts.
module tcd_top (
	input wire logic core_clk, // system clock, 100 MHz
	input wire logic reset_n, // async reset, active low
	input wire logic clkEn, // freezes all state while low
	input wire logic hsel, // ahb slave select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb transfer type
	input wire logic hwrite, // ahb write flag
	input wire logic [2:0] hsize, // ahb size, word only
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // slave response, always okay
	output logic [31:0] hrdata, // registered read data
	input wire logic port3Bit1Pin, // demod input pin a
	input wire logic port2Bit0Pin, // demod input pin b
	input wire logic port3Bit4PortData, // ordinary port data for bit 4
	input wire logic port3Bit6PortData, // ordinary port data for bit 6
	output tcd_pkg::tcd_pin_type pinOut, // registered port 3 pin levels
	output logic timerIrq // level interrupt request
);
	import tcd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// declarations
	tcd_req_type reqReg, reqNext;
	logic [31:0] rdReg, rdNext;
	logic [7:0] ctrlReg, ctrlNext;
	logic [7:0] reloadHighReg, reloadHighNext;
	logic [1:0] auxReg, auxNext;
	logic [1:0] enableReg, enableNext;
	logic [1:0] statusReg, statusNext;
	logic riseFlagReg, riseFlagNext;
	logic fallFlagReg, fallFlagNext;
	logic irqReg, irqNext;
	logic [7:0] narrowCountReg, narrowCountNext;
	logic [15:0] wideCountReg, wideCountNext;
	logic [7:0] narrowCapHighReg, narrowCapHighNext;
	logic [7:0] narrowCapLowReg, narrowCapLowNext;
	logic [7:0] wideCapHighReg, wideCapHighNext;
	logic [7:0] wideCapLowReg, wideCapLowNext;
	logic prevLevelReg, prevLevelNext;
	logic narrowOutReg, narrowOutNext;
	tcd_pin_type pinReg, pinNext;
	logic [1:0] syncLevel;
	logic [1:0] rawPins;
	logic demodLevel;
	tcd_mode_type mode;
	logic isDemod;
	logic run;
	logic [1:0] edgeSel;
	logic rawRise, rawFall;
	logic takeRise, takeFall;
	logic captureEv;
	logic timeoutEv;
	logic [7:0] wrByte;
	logic [15:0] wideReload;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	// true when the latched data phase is a write to the given index
	function automatic logic regWrite(input tcd_req_type r, input logic [5:0] idx);
		regWrite = r.valid & r.write & (r.index == idx);
	endfunction : regWrite

	// read value of one register index, unmapped reads give zero
	function automatic logic [31:0] readMux(
		input logic [5:0] idx,
		input logic [7:0] ctrlView,
		input logic [7:0] reloadHigh,
		input logic [7:0] wideLow,
		input logic [7:0] wideHigh,
		input logic [7:0] narrowLow,
		input logic [7:0] narrowHigh,
		input logic [1:0] aux,
		input logic [1:0] status,
		input logic [1:0] enable
	);
		case (idx)
			`TCD_IDX_COMMON_CONTROL: readMux = {`TCD_PAD_24, ctrlView};
			`TCD_IDX_RELOAD_HIGH: readMux = {`TCD_PAD_24, reloadHigh};
			`TCD_IDX_WIDE_CAP_LOW: readMux = {`TCD_PAD_24, wideLow};
			`TCD_IDX_WIDE_CAP_HIGH: readMux = {`TCD_PAD_24, wideHigh};
			`TCD_IDX_NARROW_CAP_LOW: readMux = {`TCD_PAD_24, narrowLow};
			`TCD_IDX_NARROW_CAP_HIGH: readMux = {`TCD_PAD_24, narrowHigh};
			`TCD_IDX_AUX_CONTROL: readMux = {`TCD_PAD_30, aux};
			`TCD_IDX_INT_STATUS: readMux = {`TCD_PAD_30, status};
			`TCD_IDX_INT_ENABLE: readMux = {`TCD_PAD_30, enable};
			default: readMux = `TCD_RD_ZERO;
		endcase
	endfunction : readMux

	////////////////////////////////////////////////////////////////////////////
	// demodulator input synchronisers
	assign rawPins = {port2Bit0Pin, port3Bit1Pin};

	// one three-stage filter per candidate pin
	generate
		for (genvar i = 0; i < 2; i++) begin : gSync
			tcd_sync uSync (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.clkEn(clkEn),
				.asyncIn(rawPins[i]),
				.levelOut(syncLevel[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// mode decode and edge events
	// mode bit steers both timers
	assign mode = tcd_mode_type'(ctrlReg[`TCD_CC_MODE]); // see R10
	assign isDemod = (mode == TCD_MODE_DEMOD); // see R11
	assign run = auxReg[`TCD_AUX_RUN];
	assign edgeSel = ctrlReg[`TCD_CC_EDGE_HI:`TCD_CC_EDGE_LO];
	assign wrByte = hwdata[7:0];
	assign wideReload = {reloadHighReg, `TCD_RST_BYTE};

	// bit 6 chooses the demodulator pin only in demod mode
	assign demodLevel = ctrlReg[`TCD_CC_SELECT] ? syncLevel[1] : syncLevel[0]; // see R12

	// raw transitions of the selected input
	assign rawRise = isDemod & run & demodLevel & ~prevLevelReg;
	assign rawFall = isDemod & run & ~demodLevel & prevLevelReg;

	// edge selection gates which transitions capture
	always_comb begin
		takeRise = 1'b0;
		takeFall = 1'b0;
		case (edgeSel)
			`TCD_EDGE_FALLING: takeFall = rawFall;
			`TCD_EDGE_RISING: takeRise = rawRise;
			`TCD_EDGE_BOTH: begin
				takeRise = rawRise;
				takeFall = rawFall;
			end
			default: takeRise = 1'b0;
		endcase
	end

	assign captureEv = takeRise | takeFall;
	assign timeoutEv = run & (narrowCountReg == `TCD_NARROW_TOP);

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: address phase latch and registered read data
	// zero wait states except while the clock enable holds the block frozen
	assign hreadyout = clkEn;
	assign hresp = 1'b0;
	assign hrdata = rdReg;

	// capture address phase and prepare read data at the same edge
	always_comb begin
		reqNext = reqReg;
		rdNext = rdReg;
		if (hready) begin
			reqNext.valid = hsel & htrans[1];
			reqNext.write = hwrite;
			reqNext.index = haddr[`TCD_ADDR_HI:`TCD_ADDR_LO];
			if (hsel & htrans[1] & ~hwrite) begin
				rdNext = readMux(haddr[`TCD_ADDR_HI:`TCD_ADDR_LO],
					isDemod ? {ctrlReg[7:2], riseFlagReg, fallFlagReg} : ctrlReg,
					reloadHighReg, wideCapLowReg, wideCapHighReg,
					narrowCapLowReg, narrowCapHighReg,
					auxReg, statusReg, enableReg); // see R5
			end
		end
	end
	// register the bus phase and the read data
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reqReg <= '0;
			rdReg <= `TCD_RD_ZERO;
		end else if (clkEn) begin
			reqReg <= reqNext;
			rdReg <= rdNext;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software control registers
	// writes land in the data phase; capture indices have no write path
	always_comb begin
		ctrlNext = ctrlReg;
		reloadHighNext = reloadHighReg;
		auxNext = auxReg;
		enableNext = enableReg;
		if (regWrite(reqReg, `TCD_IDX_COMMON_CONTROL)) begin
			ctrlNext[7:2] = wrByte[7:2]; // see R10
			if (!isDemod) begin
				ctrlNext[1:0] = wrByte[1:0];
			end
		end
		if (regWrite(reqReg, `TCD_IDX_RELOAD_HIGH)) begin
			reloadHighNext = wrByte; // see R6
		end
		if (regWrite(reqReg, `TCD_IDX_AUX_CONTROL)) begin
			auxNext = wrByte[1:0];
		end
		if (regWrite(reqReg, `TCD_IDX_INT_ENABLE)) begin
			enableNext = wrByte[1:0];
		end
	end
	// register the software control fields
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlReg <= `TCD_RST_BYTE;
			reloadHighReg <= `TCD_RST_BYTE;
			auxReg <= `TCD_RST_INT;
			enableReg <= `TCD_RST_INT;
		end else if (clkEn) begin
			ctrlReg <= ctrlNext;
			reloadHighReg <= reloadHighNext;
			auxReg <= auxNext;
			enableReg <= enableNext;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counters and capture registers
	// demod edges snapshot the running counts and restart them
	always_comb begin
		narrowCountNext = narrowCountReg;
		wideCountNext = wideCountReg;
		narrowCapHighNext = narrowCapHighReg;
		narrowCapLowNext = narrowCapLowReg;
		wideCapHighNext = wideCapHighReg;
		wideCapLowNext = wideCapLowReg;
		prevLevelNext = demodLevel;
		narrowOutNext = narrowOutReg;
		if (!run) begin
			narrowCountNext = `TCD_RST_BYTE;
			wideCountNext = wideReload;
			narrowOutNext = ctrlReg[`TCD_CC_RISE];
		end else if (captureEv) begin
			if (takeFall) begin
				narrowCapHighNext = narrowCountReg; // see R1, R14
			end
			if (takeRise) begin
				narrowCapLowNext = narrowCountReg; // see R2, R14
			end
			wideCapHighNext = wideCountReg[15:8]; // see R3
			wideCapLowNext = wideCountReg[7:0]; // see R4
			narrowCountNext = `TCD_RST_BYTE; // see R14
			wideCountNext = wideReload; // see R14
		end else begin
			narrowCountNext = narrowCountReg + `TCD_NARROW_ONE;
			wideCountNext = wideCountReg + `TCD_WIDE_ONE;
			if (timeoutEv && !isDemod) begin
				narrowOutNext = ~narrowOutReg;
			end
		end
	end
	// register counters, captures and the timer output
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			narrowCountReg <= `TCD_RST_BYTE;
			wideCountReg <= {`TCD_RST_BYTE, `TCD_RST_BYTE};
			narrowCapHighReg <= `TCD_RST_BYTE;
			narrowCapLowReg <= `TCD_RST_BYTE;
			wideCapHighReg <= `TCD_RST_BYTE;
			wideCapLowReg <= `TCD_RST_BYTE;
			prevLevelReg <= 1'b0;
			narrowOutReg <= 1'b0;
		end else if (clkEn) begin
			narrowCountReg <= narrowCountNext;
			wideCountReg <= wideCountNext;
			narrowCapHighReg <= narrowCapHighNext;
			narrowCapLowReg <= narrowCapLowNext;
			wideCapHighReg <= wideCapHighNext;
			wideCapLowReg <= wideCapLowNext;
			prevLevelReg <= prevLevelNext;
			narrowOutReg <= narrowOutNext;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// edge flags, interrupt status and request
	// sticky bits; a new event in the clearing cycle keeps its bit set
	always_comb begin
		riseFlagNext = riseFlagReg;
		fallFlagNext = fallFlagReg;
		statusNext = statusReg;
		if (regWrite(reqReg, `TCD_IDX_COMMON_CONTROL) && isDemod) begin
			if (wrByte[`TCD_CC_RISE]) begin
				riseFlagNext = 1'b0;
			end
			if (wrByte[`TCD_CC_FALL]) begin
				fallFlagNext = 1'b0;
			end
		end
		if (regWrite(reqReg, `TCD_IDX_INT_CLEAR)) begin
			statusNext = statusReg & ~wrByte[1:0];
		end
		if (takeRise) begin
			riseFlagNext = 1'b1;
		end
		if (takeFall) begin
			fallFlagNext = 1'b1;
		end
		if (captureEv) begin
			statusNext[`TCD_INT_CAPTURE] = 1'b1;
		end
		if (timeoutEv) begin
			statusNext[`TCD_INT_TIMEOUT] = 1'b1;
		end
		// request stays high while any enabled bit is pending
		irqNext = |(statusNext & enableNext); // see R7, R8
	end
	// register flags, status and the request level
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			riseFlagReg <= 1'b0;
			fallFlagReg <= 1'b0;
			statusReg <= `TCD_RST_INT;
			irqReg <= 1'b0;
		end else if (clkEn) begin
			riseFlagReg <= riseFlagNext;
			fallFlagReg <= fallFlagNext;
			statusReg <= statusNext;
			irqReg <= irqNext;
		end
	end

	assign timerIrq = irqReg;

	////////////////////////////////////////////////////////////////////////////
	// port 3 output pin selection
	// timer output may replace ordinary port data on bits 4 and 6
	always_comb begin
		pinNext.port3Bit4Pin = auxReg[`TCD_AUX_PIN4_SELECT] ? narrowOutReg
			: port3Bit4PortData; // see R9
		pinNext.port3Bit6Pin = (!isDemod && ctrlReg[`TCD_CC_SELECT]) ? narrowOutReg
			: port3Bit6PortData; // see R13
	end
	// register the pin levels so the pins never glitch
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinReg <= '0;
		end else if (clkEn) begin
			pinReg <= pinNext;
		end
	end

	assign pinOut = pinReg;

endmodule : tcd_top

/* tb/tcd_top_sva.sv */
// port-level checks for the capture/demodulation timer
`timescale 1ns/1ps

module tcd_top_sva (
	input wire logic core_clk, // system clock
	input wire logic reset_n, // async reset, active low
	input wire logic clkEn, // clock enable
	input wire logic hsel, // ahb select
	input wire logic [31:0] haddr, // ahb address
	input wire logic [1:0] htrans, // ahb type
	input wire logic hwrite, // ahb write flag
	input wire logic [31:0] hwdata, // ahb write data
	input wire logic hready, // ahb ready
	input wire logic hreadyout, // slave ready
	input wire logic [31:0] hrdata, // read data
	input wire logic port3Bit4PortData, // port data bit 4
	input wire logic port3Bit6PortData, // port data bit 6
	input wire tcd_pkg::tcd_pin_type pinOut, // pin levels
	input wire logic timerIrq // interrupt
);
	import tcd_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic take, rdTake, mapped, wrPend, modeT, b6T, sel4T;
	logic [5:0] idx, wrIdx;
	logic [1:0] live, enT;
	logic [7:0] reloadT;
	assign take = hsel & hready & htrans[1] & clkEn;
	assign rdTake = take & ~hwrite;
	assign idx = haddr[7:2];
	assign mapped = idx inside {6'h01, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h10, 6'h11, 6'h12, 6'h13};
	////////////////////////////////////////////////////////////////////////////////
	// follow software writes so the checks know the programmed state
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			{live, wrPend, wrIdx, modeT, b6T, sel4T, enT, reloadT} <= '0;
		end else if (clkEn) begin
			live <= {live[0], 1'h1};
			wrPend <= take & hwrite;
			wrIdx <= idx;
			if (wrPend && wrIdx == 6'h01) {modeT, b6T} <= hwdata[7:6];
			if (wrPend && wrIdx == 6'h07) reloadT <= hwdata[7:0];
			if (wrPend && wrIdx == 6'h10) sel4T <= hwdata[1];
			if (wrPend && wrIdx == 6'h12) enT <= hwdata[1:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// assertions
	a_ready_follows: assert property (hreadyout == clkEn)
		else $error("ready does not follow clock enable");
	a_upper_zero: assert property (rdTake |=> hrdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_unmapped_zero: assert property (rdTake && !mapped |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_read_holds: assert property (!rdTake |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_reload_readback: assert property (rdTake && idx == 6'h07 |=> hrdata[7:0] == $past(reloadT))
		else $error("reload byte readback wrong");
	a_mode_readback: assert property (rdTake && idx == 6'h01 |=> hrdata[7] == $past(modeT))
		else $error("mode bit readback wrong");
	a_irq_masked: assert property (live[1] && enT == 2'h0 && $past(enT) == 2'h0 |-> !timerIrq)
		else $error("interrupt while all enables clear");
	a_pin4_port: assert property (live[1] && $past(clkEn) && !$past(sel4T) && !$past(sel4T, 2)
		|-> pinOut.port3Bit4Pin == $past(port3Bit4PortData))
		else $error("pin 4 not following port data");
	a_pin6_port: assert property (live[1] && $past(clkEn) && !$past(modeT) && !$past(b6T)
		&& !$past(modeT, 2) && !$past(b6T, 2) |-> pinOut.port3Bit6Pin == $past(port3Bit6PortData))
		else $error("pin 6 not following port data");
	c_irq: cover property (timerIrq);
	c_cap_read: cover property (rdTake && idx == 6'h0B);
	c_pin4_timer: cover property (sel4T && $changed(pinOut.port3Bit4Pin));
endmodule : tcd_top_sva

bind tcd_top tcd_top_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.port3Bit4PortData(port3Bit4PortData), .port3Bit6PortData(port3Bit6PortData),
	.pinOut(pinOut), .timerIrq(timerIrq));

/* tb/tcd_top_bench.sv */
// self-checking bench for the capture/demodulation timer
`timescale 1ns/1ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin miscompares++; \
	$display("Error %0t: got %h expected %h", $time, got, exp); end end

module tcd_top_bench;
	import tcd_pkg::*;
	localparam logic [7:0] CTRL = 8'h04, RELOAD = 8'h1C, WCAPL = 8'h20, WCAPH = 8'h24;
	localparam logic [7:0] NCAPL = 8'h28, NCAPH = 8'h2C, AUX = 8'h40, STAT = 8'h44;
	localparam logic [7:0] ENAB = 8'h48, CLR = 8'h4C, NOREG = 8'h3C;
	int nTests = 0;
	int miscompares = 0;
	logic core_clk = 1'h0, reset_n = 1'h0, clkEn = 1'h1, hsel = 1'h0, hwrite = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hready, hreadyout, hresp, timerIrq;
	logic port3Bit1Pin = 1'h0, port2Bit0Pin = 1'h0, port3Bit4PortData = 1'h0;
	logic port3Bit6PortData = 1'h0;
	tcd_pin_type pinOut;
	assign hready = hreadyout;
	always #5 core_clk = ~core_clk;
	tcd_top dut (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.port3Bit1Pin(port3Bit1Pin), .port2Bit0Pin(port2Bit0Pin),
		.port3Bit4PortData(port3Bit4PortData), .port3Bit6PortData(port3Bit6PortData),
		.pinOut(pinOut), .timerIrq(timerIrq));
	////////////////////////////////////////////////////////////////////////////////
	// bus and timing helpers
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic waitRdy;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hready !== 1'h1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			$display("Error %0t: bus hang", $time);
		end
	endtask : waitRdy
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		waitRdy();
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		waitRdy();
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 8'h00, q);
		`CHK(q, e)
	endtask : rdChk
	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic tReset;
		logic [7:0] regs [7];
		regs = '{CTRL, RELOAD, WCAPL, WCAPH, NCAPL, NCAPH, STAT};
		foreach (regs[i]) rdChk(regs[i], 32'h0);
		`CHK(timerIrq, 1'h0)
		`CHK(hresp, 1'h0)
		`CHK(pinOut, 2'h0)
	endtask : tReset
	task automatic tRegs;
		logic [7:0] caps [5];
		caps = '{WCAPL, WCAPH, NCAPL, NCAPH, NOREG};
		wr(RELOAD, 8'hA5);
		rdChk(RELOAD, 32'hA5);
		wr(RELOAD, 8'h3C);
		rdChk(RELOAD, 32'h3C);
		foreach (caps[i]) wr(caps[i], 8'h5A);
		foreach (caps[i]) rdChk(caps[i], 32'h0);
		clkEn <= 1'h0;
		tick(2);
		`CHK(hreadyout, 1'h0)
		clkEn <= 1'h1;
		tick(1);
	endtask : tRegs
	task automatic tPins;
		port3Bit4PortData <= 1'h1;
		port3Bit6PortData <= 1'h1;
		tick(3);
		`CHK(pinOut, 2'h3)
		port3Bit4PortData <= 1'h0;
		port3Bit6PortData <= 1'h0;
		tick(3);
		`CHK(pinOut, 2'h0)
	endtask : tPins
	task automatic tTimeout;
		logic p;
		wr(AUX, 8'h03);
		tick(300);
		rdChk(STAT, 32'h2);
		`CHK(timerIrq, 1'h0)
		p = pinOut.port3Bit4Pin;
		tick(256);
		`CHK(pinOut.port3Bit4Pin, ~p)
		wr(ENAB, 8'h02);
		tick(2);
		`CHK(timerIrq, 1'h1)
		wr(AUX, 8'h00);
		wr(CLR, 8'h02);
		tick(2);
		`CHK(timerIrq, 1'h0)
		rdChk(STAT, 32'h0);
		wr(ENAB, 8'h00);
	endtask : tTimeout
	task automatic tDemod;
		logic [31:0] h, l, w;
		wr(CTRL, 8'hA0);
		wr(RELOAD, 8'h12);
		wr(ENAB, 8'h01);
		wr(AUX, 8'h01);
		port3Bit1Pin <= 1'h1;
		tick(40);
		port3Bit1Pin <= 1'h0;
		tick(25);
		port3Bit1Pin <= 1'h1;
		tick(10);
		`CHK(timerIrq, 1'h1)
		bus(1'h0, NCAPH, 8'h00, h);
		bus(1'h0, NCAPL, 8'h00, l);
		`CHK(h[7:0] - l[7:0], 8'h0F)
		`CHK(h[7:0] > 8'h26 && h[7:0] < 8'h2A, 1'h1)
		rdChk(WCAPH, 32'h12);
		bus(1'h0, WCAPL, 8'h00, w);
		`CHK(w, l)
		rdChk(CTRL, 32'hA3);
		wr(CLR, 8'h01);
		wr(CTRL, 8'hD3);
		port3Bit1Pin <= 1'h0;
		tick(10);
		port3Bit1Pin <= 1'h1;
		tick(10);
		rdChk(STAT, 32'h0);
		port2Bit0Pin <= 1'h1;
		tick(10);
		rdChk(STAT, 32'h1);
		rdChk(CTRL, 32'hD2);
		wr(AUX, 8'h00);
		wr(ENAB, 8'h00);
	endtask : tDemod
	////////////////////////////////////////////////////////////////////////////////
	// verdict and run control
	task automatic stopTest;
		$display("tests %0d miscompares %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stopTest
	initial begin
		#100000;
		miscompares++;
		$display("Error %0t: watchdog expired", $time);
		stopTest();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		reset_n <= 1'h1;
		@(posedge core_clk);
		tReset();
		tRegs();
		tPins();
		tTimeout();
		tDemod();
		stopTest();
	end
endmodule : tcd_top_bench
